// [logic/audio_clock_dividers.sv]
// audio clock dividers: voice (pcm), density modulation (pdm) and rate converter
// assumes an APB master on clk and an external density clock pin from another domain
`timescale 1ns/1ps
`default_nettype none
module audio_clock_dividers (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [audio_clk_pkg::ADDR_W-1:0] paddr,
    input wire logic [audio_clk_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [audio_clk_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // voice clock to the pcm unit
    output logic voice_clk,
    output logic voice_tick,
    // density clock to the pdm unit and its pin
    input wire logic density_clk_in,
    output logic density_clk_out,
    output logic density_clk_oe,
    output logic density_clk,
    output logic density_tick,
    // rate converter clock
    output logic rate_clk,
    output logic rate_tick
);
    import audio_clk_pkg::*;

    // merges the low two byte lanes of a write into a 16-bit register image
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0] old_v,
        input logic [DATA_W-1:0] wd,
        input logic [3:0] strb
    );
        lane_merge = old_v;
        if (strb[0]) begin
            lane_merge[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            lane_merge[15:8] = wd[15:8];
        end
    endfunction

    // register state
    logic [VC_CTRL_W-1:0] vc_ctrl_q;
    logic [FRAC_W-1:0] vc_frac_q;
    logic [DM_CTRL_W-1:0] dm_ctrl_q;
    logic [RC_CTRL_W-1:0] rc_ctrl_q;

    // bus state
    logic pready_q;
    logic pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic access;
    logic done;
    logic hit;
    logic wr;
    logic [DATA_W-1:0] rd_mux;

    // density pin synchroniser and edge memory
    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_last_q;

    // output flops
    logic voice_clk_q;
    logic voice_tick_q;
    logic density_clk_q;
    logic density_tick_q;
    logic density_out_q;
    logic density_oe_q;
    logic rate_clk_q;
    logic rate_tick_q;

    div_port_if #(.DIV_W(VC_DIV_W), .FRAC_W(FRAC_W)) vc_if ();
    div_port_if #(.DIV_W(DM_DIV_W), .FRAC_W(FRAC_W)) dm_if ();
    div_port_if #(.DIV_W(RC_DIV_W), .FRAC_W(FRAC_W)) rc_if ();

    // bus decode
    assign access = psel && penable;
    assign done = access && pready_q;
    assign hit = (paddr == VOICE_DIV_ADDR) || (paddr == VOICE_FRAC_ADDR) ||
                 (paddr == DENSITY_ADDR) || (paddr == RATE_ADDR) || (paddr == STATUS_ADDR);
    assign wr = done && pwrite && hit;

    always_comb begin
        rd_mux = RDATA_NONE;
        case (paddr)
            VOICE_DIV_ADDR: begin
                rd_mux = DATA_W'(vc_ctrl_q);
            end
            VOICE_FRAC_ADDR: begin
                rd_mux = DATA_W'(vc_frac_q);
            end
            DENSITY_ADDR: begin
                rd_mux = DATA_W'(dm_ctrl_q);
            end
            RATE_ADDR: begin
                rd_mux = DATA_W'(rc_ctrl_q);
            end
            STATUS_ADDR: begin
                rd_mux[ST_VOICE_BIT] = voice_clk_q;
                rd_mux[ST_DENSITY_BIT] = density_clk_q;
                rd_mux[ST_RATE_BIT] = rate_clk_q;
                rd_mux[ST_EXT_BIT] = ext_sync_q;
            end
            default: begin
                rd_mux = RDATA_NONE;
            end
        endcase
    end

    // one wait state: pready rises in the second access cycle, read data latched with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RDATA_NONE;
        end else if (access && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !hit;
            prdata_q <= (pwrite || !hit) ? RDATA_NONE : rd_mux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // divider and enable land on the same edge when written together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vc_ctrl_q <= VC_CTRL_RST;
        end else if (wr && paddr == VOICE_DIV_ADDR) begin
            vc_ctrl_q <= VC_CTRL_W'(lane_merge(REG_W'(vc_ctrl_q), pwdata, pstrb));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vc_frac_q <= FRAC_RST;
        end else if (wr && paddr == VOICE_FRAC_ADDR) begin
            vc_frac_q <= lane_merge(vc_frac_q, pwdata, pstrb);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dm_ctrl_q <= DM_CTRL_RST;
        end else if (wr && paddr == DENSITY_ADDR) begin
            dm_ctrl_q <= DM_CTRL_W'(lane_merge(REG_W'(dm_ctrl_q), pwdata, pstrb));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_ctrl_q <= RC_CTRL_RST;
        end else if (wr && paddr == RATE_ADDR) begin
            rc_ctrl_q <= RC_CTRL_W'(lane_merge(REG_W'(rc_ctrl_q), pwdata, pstrb));
        end
    end

    // channel controls; only the voice channel carries a stretch pattern
    assign vc_if.en = vc_ctrl_q[VC_EN_BIT];
    assign vc_if.div = vc_ctrl_q[VC_DIV_W-1:0];
    assign vc_if.frac = vc_frac_q;
    // in slave mode the internal divider idles to save power
    assign dm_if.en = dm_ctrl_q[DM_EN_BIT] && dm_ctrl_q[DM_MASTER_BIT];
    assign dm_if.div = dm_ctrl_q[DM_DIV_W-1:0];
    assign dm_if.frac = '0;
    assign rc_if.en = rc_ctrl_q[RC_EN_BIT];
    assign rc_if.div = rc_ctrl_q[RC_DIV_W-1:0];
    assign rc_if.frac = '0;

    frac_clk_div #(.DIV_W(VC_DIV_W), .FRAC_W(FRAC_W)) u_voice_div (
        .clk(clk),
        .rst_n(rst_n),
        .port(vc_if.gen)
    );

    frac_clk_div #(.DIV_W(DM_DIV_W), .FRAC_W(FRAC_W)) u_density_div (
        .clk(clk),
        .rst_n(rst_n),
        .port(dm_if.gen)
    );

    frac_clk_div #(.DIV_W(RC_DIV_W), .FRAC_W(FRAC_W)) u_rate_div (
        .clk(clk),
        .rst_n(rst_n),
        .port(rc_if.gen)
    );

    // external density clock comes from another domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_last_q <= 1'b0;
        end else begin
            ext_meta_q <= density_clk_in;
            ext_sync_q <= ext_meta_q;
            ext_last_q <= ext_sync_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            voice_clk_q <= 1'b0;
            voice_tick_q <= 1'b0;
        end else begin
            voice_clk_q <= vc_if.clk_lvl;
            voice_tick_q <= vc_if.tick;
        end
    end

    // master drives its own divided clock, slave follows the pin at three cycles latency
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            density_clk_q <= 1'b0;
            density_tick_q <= 1'b0;
            density_out_q <= 1'b0;
            density_oe_q <= 1'b0;
        end else if (!dm_ctrl_q[DM_EN_BIT]) begin
            density_clk_q <= 1'b0;
            density_tick_q <= 1'b0;
            density_out_q <= 1'b0;
            density_oe_q <= 1'b0;
        end else if (dm_ctrl_q[DM_MASTER_BIT]) begin
            density_clk_q <= dm_if.clk_lvl;
            density_tick_q <= dm_if.tick;
            density_out_q <= dm_if.clk_lvl;
            density_oe_q <= 1'b1;
        end else begin
            density_clk_q <= ext_sync_q;
            density_tick_q <= ext_sync_q && !ext_last_q;
            density_out_q <= 1'b0;
            density_oe_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_clk_q <= 1'b0;
            rate_tick_q <= 1'b0;
        end else begin
            rate_clk_q <= rc_if.clk_lvl;
            rate_tick_q <= rc_if.tick;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign voice_clk = voice_clk_q;
    assign voice_tick = voice_tick_q;
    assign density_clk_out = density_out_q;
    assign density_clk_oe = density_oe_q;
    assign density_clk = density_clk_q;
    assign density_tick = density_tick_q;
    assign rate_clk = rate_clk_q;
    assign rate_tick = rate_tick_q;

    chk_apb_wait_state: assert property (@(posedge clk) disable iff (!rst_n)
        psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb answer not given after one wait state");

    chk_voice_off: assert property (@(posedge clk) disable iff (!rst_n)
        !vc_ctrl_q[VC_EN_BIT] [*2] |=> !voice_clk_q && !voice_tick_q)
        else $error("voice clock active while disabled");

    chk_voice_start: assert property (@(posedge clk) disable iff (!rst_n)
        !vc_ctrl_q[VC_EN_BIT] ##1 vc_ctrl_q[VC_EN_BIT] [*2] |=> voice_tick_q && voice_clk_q)
        else $error("voice clock did not start two cycles after enable");

    chk_density_off: assert property (@(posedge clk) disable iff (!rst_n)
        !dm_ctrl_q[DM_EN_BIT] |=> !density_clk_q && !density_oe_q)
        else $error("density clock active while disabled");

    chk_master_drive: assert property (@(posedge clk) disable iff (!rst_n)
        dm_ctrl_q[DM_EN_BIT] |=> density_oe_q == $past(dm_ctrl_q[DM_MASTER_BIT]))
        else $error("density pin drive does not follow master select");

    chk_slave_follow: assert property (@(posedge clk) disable iff (!rst_n)
        dm_ctrl_q[DM_EN_BIT] && !dm_ctrl_q[DM_MASTER_BIT] |=> density_clk_q == $past(ext_sync_q))
        else $error("slave density clock does not follow the pin");

    chk_rate_off: assert property (@(posedge clk) disable iff (!rst_n)
        !rc_ctrl_q[RC_EN_BIT] [*2] |=> !rate_clk_q && !rate_tick_q)
        else $error("rate clock active while disabled");
endmodule
`default_nettype wire

// [logic/audio_clk_pkg.sv]
// audio clock divider constants: register map, field layout, reset values
// assumes a 32-bit APB slave with 12-bit byte address inside the block window
package audio_clk_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // printed offsets are not word aligned: kept as indices, byte address = 4 x index
    localparam logic [31:0] BLOCK_BASE = 32'h50001c40;
    localparam logic [31:0] VOICE_DIV_IDX = 32'h50001c40;
    localparam logic [31:0] VOICE_FRAC_IDX = 32'h50001c42;
    localparam logic [31:0] DENSITY_IDX = 32'h50001c44;
    localparam logic [31:0] RATE_IDX = 32'h50001c46;
    localparam logic [ADDR_W-1:0] VOICE_DIV_ADDR = ADDR_W'((VOICE_DIV_IDX - BLOCK_BASE) * 4);
    localparam logic [ADDR_W-1:0] VOICE_FRAC_ADDR = ADDR_W'((VOICE_FRAC_IDX - BLOCK_BASE) * 4);
    localparam logic [ADDR_W-1:0] DENSITY_ADDR = ADDR_W'((DENSITY_IDX - BLOCK_BASE) * 4);
    localparam logic [ADDR_W-1:0] RATE_ADDR = ADDR_W'((RATE_IDX - BLOCK_BASE) * 4);
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h020;

    // voice (pcm) control
    localparam int VC_EN_BIT = 12;
    localparam int VC_DIV_W = 12;
    localparam int VC_CTRL_W = 14;
    localparam logic [VC_CTRL_W-1:0] VC_CTRL_RST = 14'h0000;
    localparam int FRAC_W = 16;
    localparam logic [FRAC_W-1:0] FRAC_RST = 16'h0000;

    // density modulation (pdm) control
    localparam int DM_MASTER_BIT = 9;
    localparam int DM_EN_BIT = 8;
    localparam int DM_DIV_W = 8;
    localparam int DM_CTRL_W = 10;
    localparam logic [DM_CTRL_W-1:0] DM_CTRL_RST = 10'h000;

    // rate converter control
    localparam int RC_EN_BIT = 8;
    localparam int RC_DIV_W = 8;
    localparam int RC_CTRL_W = 9;
    localparam logic [RC_CTRL_W-1:0] RC_CTRL_RST = 9'h000;

    // status bit positions
    localparam int ST_VOICE_BIT = 0;
    localparam int ST_DENSITY_BIT = 1;
    localparam int ST_RATE_BIT = 2;
    localparam int ST_EXT_BIT = 3;
    localparam int ST_W = 4;

    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h00000000;
endpackage

// [logic/div_port_if.sv]
// control and clock outputs of one divider channel
// assumes one controller and one generator on the same clock
`timescale 1ns/1ps
`default_nettype none
interface div_port_if #(parameter int DIV_W = 12, parameter int FRAC_W = 16);
    logic en;
    logic [DIV_W-1:0] div;
    logic [FRAC_W-1:0] frac;
    logic clk_lvl;
    logic tick;
    modport ctrl (output en, output div, output frac, input clk_lvl, input tick);
    modport gen (input en, input div, input frac, output clk_lvl, output tick);
endinterface
`default_nettype wire

// [logic/frac_clk_div.sv]
// one integer divider with optional fractional stretch pattern
// assumes en, div and frac come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module frac_clk_div #(
    parameter int DIV_W = 12,
    parameter int FRAC_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // channel
    div_port_if.gen port
);
    localparam int CNT_W = DIV_W + 1;
    localparam int PH_W = (FRAC_W > 1) ? $clog2(FRAC_W) : 1;

    // highest set bit of the pattern; zero when the pattern is empty
    function automatic logic [PH_W-1:0] top_bit(input logic [FRAC_W-1:0] p);
        top_bit = '0;
        for (int i = 0; i < FRAC_W; i++) begin
            if (p[i]) begin
                top_bit = PH_W'(i);
            end
        end
    endfunction

    logic [CNT_W-1:0] cnt_q;
    logic [PH_W-1:0] phase_q;
    logic clk_q;
    logic tick_q;
    logic [CNT_W-1:0] base;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] high_len;
    logic ext;
    logic wrap;

    // a divider of zero runs as divide by one rather than freezing the clock
    assign base = (port.div == '0) ? CNT_W'(1) : CNT_W'(port.div);
    assign ext = (port.frac != '0) && port.frac[phase_q];
    assign period = base + CNT_W'(ext);
    assign high_len = CNT_W'((period + CNT_W'(1)) >> 1);
    assign wrap = (cnt_q >= period - CNT_W'(1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!port.en) begin
            cnt_q <= '0;
        end else if (wrap) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // pattern walked from its top bit down, then round again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
        end else if (!port.en) begin
            phase_q <= top_bit(port.frac);
        end else if (wrap) begin
            phase_q <= (phase_q == '0) ? top_bit(port.frac) : phase_q - PH_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            clk_q <= port.en && (cnt_q < high_len);
            tick_q <= port.en && (cnt_q == '0);
        end
    end

    assign port.clk_lvl = clk_q;
    assign port.tick = tick_q;

    chk_stop_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        !port.en |=> (cnt_q == '0) && !clk_q && !tick_q)
        else $error("divider not held cleared while disabled");

    chk_clean_start: assert property (@(posedge clk) disable iff (!rst_n)
        !port.en ##1 port.en |=> tick_q && clk_q)
        else $error("divider did not start a fresh period");

    chk_stretch_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        port.en && ext && (cnt_q == base - CNT_W'(1)) |=> cnt_q == $past(base))
        else $error("set pattern bit did not lengthen the period");

    chk_phase_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        port.en && wrap && (phase_q == '0) |=> phase_q == $past(top_bit(port.frac)))
        else $error("pattern walk did not restart at its top bit");
endmodule
`default_nettype wire

// [tb/audio_unit_model.sv]
// behavioural pcm, pdm and rate converter units fed by the dividers
// assumes the bench resolves the density pin from the divider's pin drive enable alone
`timescale 1ns/1ps
`default_nettype none
module audio_unit_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // clocks from the dividers
    input wire logic voice_tick,
    input wire logic density_tick,
    input wire logic rate_tick,
    // external density clock source
    input wire logic pin_run,
    output logic ext_clk,
    // activity counters
    output var int voice_count,
    output var int density_count,
    output var int rate_count,
    output var int pin_edges
);
    logic ext_q;

    // pin clock stands low between bursts; half period unrelated to clk
    initial begin
        ext_clk = 1'b0;
        forever begin
            #155;
            ext_clk = pin_run ? ~ext_clk : 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
            voice_count <= 0;
            density_count <= 0;
            rate_count <= 0;
            pin_edges <= 0;
        end else begin
            ext_q <= ext_clk;
            voice_count <= voice_count + int'(voice_tick);
            density_count <= density_count + int'(density_tick);
            rate_count <= rate_count + int'(rate_tick);
            pin_edges <= pin_edges + int'(ext_clk & ~ext_q);
        end
    end
endmodule
`default_nettype wire

// [tb/test_audio_clock_dividers.sv]
// self-checking bench for the audio clock dividers
// assumes the design package and the unit model on the far side
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module test_audio_clock_dividers;
    import audio_clk_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin_run, ext_clk;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic voice_clk, voice_tick, dm_out, dm_oe, density_clk, density_tick, rate_clk, rate_tick;
    wire logic density_pin;
    logic [2:0] ticks, lvls;
    int voice_count, density_count, rate_count, pin_edges;
    int num_errors = 0;
    int total_checks = 0;

    assign density_pin = dm_oe ? dm_out : ext_clk;
    assign ticks = {rate_tick, density_tick, voice_tick};
    assign lvls = {rate_clk, density_clk, voice_clk};

    audio_clock_dividers u_audio_clock_dividers (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .voice_clk(voice_clk), .voice_tick(voice_tick), .density_clk_in(density_pin),
        .density_clk_out(dm_out), .density_clk_oe(dm_oe), .density_clk(density_clk),
        .density_tick(density_tick), .rate_clk(rate_clk), .rate_tick(rate_tick));

    audio_unit_model u_audio_unit_model (.clk(clk), .rst_n(rst_n), .voice_tick(voice_tick),
        .density_tick(density_tick), .rate_tick(rate_tick), .pin_run(pin_run), .ext_clk(ext_clk),
        .voice_count(voice_count), .density_count(density_count), .rate_count(rate_count),
        .pin_edges(pin_edges));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [3:0] s, output logic [DATA_W-1:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHECK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s = 4'hf,
                      input logic exp_err = 1'b0);
        logic [DATA_W-1:0] rd;
        logic err;
        apb(1'b1, a, d, s, rd, err);
        `CHECK(err, exp_err)
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic exp_err);
        logic [DATA_W-1:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, 4'hf, rd, err);
        `CHECK(rd, exp)
        `CHECK(err, exp_err)
    endtask

    // waits for the next tick of one channel, bounded
    task automatic sync(input int ch, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ticks[ch] !== 1'b1 && n < 600);
        `CHECK(ticks[ch], 1'b1)
    endtask

    // called just after a tick edge; returns length and high cycles of one period
    task automatic period(input int ch, output int len, output int hi);
        len = 0;
        hi = 0;
        do begin
            hi += int'(lvls[ch]);
            len++;
            @(posedge clk);
        end while (ticks[ch] !== 1'b1 && len < 600);
    endtask

    task automatic run_chk(input int ch, input int exp, input int reps);
        int len, hi;
        repeat (reps) begin
            period(ch, len, hi);
            `CHECK(len, exp)
            `CHECK(hi, (exp + 1) / 2)
        end
    endtask

    task automatic t_regs();
        rd_chk(VOICE_DIV_ADDR, 32'h0, 1'b0);
        rd_chk(VOICE_FRAC_ADDR, 32'h0, 1'b0);
        rd_chk(DENSITY_ADDR, 32'h0, 1'b0);
        rd_chk(RATE_ADDR, 32'h0, 1'b0);
        rd_chk(STATUS_ADDR, 32'h0, 1'b0);
        rd_chk(12'h004, 32'h0, 1'b1);
        wr(12'h030, 32'hffffffff, 4'hf, 1'b1);
        wr(STATUS_ADDR, 32'hffffffff);
        wr(VOICE_DIV_ADDR, 32'hffffffff, 4'h1);
        rd_chk(VOICE_DIV_ADDR, 32'h000000ff, 1'b0);
        wr(VOICE_DIV_ADDR, 32'hffffefff);
        rd_chk(VOICE_DIV_ADDR, 32'h00002fff, 1'b0);
        wr(VOICE_FRAC_ADDR, 32'hffffffff);
        rd_chk(VOICE_FRAC_ADDR, 32'h0000ffff, 1'b0);
        wr(VOICE_FRAC_ADDR, 32'h0000a5c3, 4'h2);
        rd_chk(VOICE_FRAC_ADDR, 32'h0000a5ff, 1'b0);
        wr(DENSITY_ADDR, 32'hfffffeff);
        rd_chk(DENSITY_ADDR, 32'h000002ff, 1'b0);
        wr(RATE_ADDR, 32'hfffffeff);
        rd_chk(RATE_ADDR, 32'h000000ff, 1'b0);
        `CHECK(ticks, 3'b000)
        wr(VOICE_DIV_ADDR, 32'h0);
        wr(VOICE_FRAC_ADDR, 32'h0);
        wr(DENSITY_ADDR, 32'h0);
        wr(RATE_ADDR, 32'h0);
    endtask

    task automatic t_voice();
        int n, busy;
        wr(VOICE_DIV_ADDR, 32'h00001004);
        sync(0, n);
        run_chk(0, 4, 4);
        wr(VOICE_DIV_ADDR, 32'h00000004);
        repeat (3) @(posedge clk);
        busy = 0;
        repeat (40) begin
            @(posedge clk);
            busy += int'(voice_clk | voice_tick);
        end
        `CHECK(busy, 0)
        wr(VOICE_DIV_ADDR, 32'h00001005);
        sync(0, n);
        `CHECK(n <= 4, 1'b1)
        run_chk(0, 5, 3);
        wr(VOICE_DIV_ADDR, 32'h0);
    endtask

    task automatic t_frac(input logic [15:0] pat, input int dv);
        int m, len, hi, n;
        m = 15;
        while (m > 0 && pat[m] !== 1'b1) m--;
        wr(VOICE_FRAC_ADDR, {16'h0, pat});
        wr(VOICE_DIV_ADDR, 32'h1000 + 32'(dv));
        sync(0, n);
        for (int i = m; i >= 0; i--) begin
            period(0, len, hi);
            `CHECK(len, dv + int'(pat[i]))
        end
        wr(VOICE_DIV_ADDR, 32'h0);
        wr(VOICE_FRAC_ADDR, 32'h0);
    endtask

    task automatic t_density();
        int d0, p0, n;
        wr(DENSITY_ADDR, 32'h00000100);
        d0 = density_count;
        p0 = pin_edges;
        pin_run <= 1'b1;
        repeat (200) @(posedge clk);
        pin_run <= 1'b0;
        repeat (30) @(posedge clk);
        `CHECK(dm_oe, 1'b0)
        `CHECK(pin_edges - p0 > 5, 1'b1)
        `CHECK(density_count - d0, pin_edges - p0)
        pin_run <= 1'b1;
        wr(DENSITY_ADDR, 32'h00000306);
        sync(1, n);
        `CHECK(dm_oe, 1'b1)
        `CHECK(dm_out, 1'b1)
        run_chk(1, 6, 4);
        pin_run <= 1'b0;
        wr(DENSITY_ADDR, 32'h00000206);
        repeat (4) @(posedge clk);
        `CHECK({dm_oe, dm_out, density_clk}, 3'b000)
        wr(DENSITY_ADDR, 32'h0);
    endtask

    task automatic t_rate();
        int n;
        wr(RATE_ADDR, 32'h000001ff);
        sync(2, n);
        run_chk(2, 255, 2);
        wr(RATE_ADDR, 32'h0);
        wr(RATE_ADDR, 32'h00000101);
        sync(2, n);
        run_chk(2, 1, 3);
        wr(RATE_ADDR, 32'h0);
        // a zero divider runs as divide by one
        wr(RATE_ADDR, 32'h00000100);
        sync(2, n);
        run_chk(2, 1, 3);
        wr(RATE_ADDR, 32'h0);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        pin_run = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_voice();
        t_frac(16'h0110, 4);
        t_frac(16'hfeee, 2);
        t_density();
        t_rate();
        give_verdict();
    end

    // whole run needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
